// >>> hw/count_src_sel.sv
// count-source selector for a 16-bit general timer
`timescale 1ns/1ps
`default_nettype none
`include "count_src_regs.svh"

module count_src_sel (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      reset,
    // configuration from software
    input  wire count_src_pkg::cfg_s       cfg,
    // clock enables from the clock generator
    input  wire logic                      cpu_tick,
    input  wire logic                      high_speed_osc_clock,
    input  wire logic                      main_system_clock,
    input  wire logic                      subsystem_clock,
    // external count clock pin
    input  wire logic                      ext_count_clock_pin,
    // to the timer counter core
    output logic                           count_tick,
    output count_src_pkg::count_src_e      count_src,
    output logic                           setting_prohibited
);

    logic                      div2_tick;
    logic                      div4_tick;
    logic                      div8_tick;
    logic                      div32_tick;
    logic                      pin_r;
    logic                      pin_nxt;
    logic                      tick_r;
    logic                      tick_nxt;
    count_src_pkg::count_src_e src_r;
    count_src_pkg::count_src_e src_nxt;
    count_src_pkg::count_src_e src_dec;
    logic                      prohib_r;
    logic                      prohib_nxt;
    logic                      pin_rise;

    // ****************************************************************
    // prescaler
    // ****************************************************************
    // the prescaler runs free and is not restarted when the code changes,
    // so the first divided tick after a switch can come early;
    // the counter core must tolerate one short first period
    clk_prescaler u_presc (
        .mclk       (mclk),
        .reset      (reset),
        .cpu_tick   (cpu_tick),
        .div2_tick  (div2_tick),
        .div4_tick  (div4_tick),
        .div8_tick  (div8_tick),
        .div32_tick (div32_tick)
    );

    // ****************************************************************
    // legality and source decode
    // ****************************************************************
    // divided cpu clock for codes 000-100, external pin for 101, off otherwise
    function automatic count_src_pkg::count_src_e div_src(input logic [2:0] code);
        count_src_pkg::count_src_e s;
        case (code)
            `CSRC_CODE_DIV1:  s = count_src_pkg::SRC_CLK_DIV1;
            `CSRC_CODE_DIV2:  s = count_src_pkg::SRC_CLK_DIV2;
            `CSRC_CODE_DIV4:  s = count_src_pkg::SRC_CLK_DIV4;
            `CSRC_CODE_DIV8:  s = count_src_pkg::SRC_CLK_DIV8;
            `CSRC_CODE_DIV32: s = count_src_pkg::SRC_CLK_DIV32;
            `CSRC_CODE_EXT:   s = count_src_pkg::SRC_EXT_PIN;
            default:          s = count_src_pkg::SRC_OFF;
        endcase
        return s;
    endfunction

    // ****************************************************************
    // legal settings, row by row
    // ****************************************************************
    // low range, cpu domain, any cpu source:
    //   000-100 cpu clock /1 /2 /4 /8 /32, 101 external pin
    // low range, subsystem domain:
    //   ls osc or xt1: 000 subsystem clock, 101 external pin
    //   hs osc, x1 or pll: nothing legal
    // high range, cpu domain:
    //   hs osc: 000 hs osc clock, 101 external pin
    //   pll: 000 main system clock, 101 external pin
    //   ls osc, x1 or xt1: 101 external pin only
    // high range, subsystem domain:
    //   ls osc: 000 hs osc clock, 101 external pin
    //   xt1: 000 subsystem clock, 101 external pin
    //   pll: 101 external pin only
    //   hs osc or x1: nothing legal
    // anything else, codes 110 and 111 and the external pin in
    // third pwm mode decode to off, with the counter clock gated

    // full table: every unlisted combination falls to off
    function automatic count_src_pkg::count_src_e decode(input count_src_pkg::cfg_s c);
        count_src_pkg::count_src_e s;
        logic                      is_ext;
        logic                      is_0;
        is_ext = (c.count_source_code == `CSRC_CODE_EXT);
        is_0   = (c.count_source_code == `CSRC_CODE_DIV1);
        s      = count_src_pkg::SRC_OFF;
        if (!c.osc_high_range_sel && !c.timer_clk_domain_sel) begin
            s = div_src(c.count_source_code);
        end else if (!c.osc_high_range_sel) begin
            // low range, subsystem domain
            case (c.cpu_clock_src_sel)
                count_src_pkg::CPU_LS_OSC,
                count_src_pkg::CPU_XT1: begin
                    if (is_0) begin
                        s = count_src_pkg::SRC_SUB;
                    end else if (is_ext) begin
                        s = count_src_pkg::SRC_EXT_PIN;
                    end
                end
                default: s = count_src_pkg::SRC_OFF;
            endcase
        end else if (!c.timer_clk_domain_sel) begin
            // high range, cpu domain: only ext, plus 000 on hs osc or pll
            if (is_ext) begin
                s = count_src_pkg::SRC_EXT_PIN;
            end else if (is_0) begin
                case (c.cpu_clock_src_sel)
                    count_src_pkg::CPU_HS_OSC: s = count_src_pkg::SRC_HS_OSC;
                    count_src_pkg::CPU_PLL:    s = count_src_pkg::SRC_MAIN;
                    default:                   s = count_src_pkg::SRC_OFF;
                endcase
            end
        end else begin
            // high range, subsystem domain
            case (c.cpu_clock_src_sel)
                count_src_pkg::CPU_LS_OSC: begin
                    if (is_0) begin
                        s = count_src_pkg::SRC_HS_OSC;
                    end else if (is_ext) begin
                        s = count_src_pkg::SRC_EXT_PIN;
                    end
                end
                count_src_pkg::CPU_XT1: begin
                    if (is_0) begin
                        s = count_src_pkg::SRC_SUB;
                    end else if (is_ext) begin
                        s = count_src_pkg::SRC_EXT_PIN;
                    end
                end
                count_src_pkg::CPU_PLL: begin
                    if (is_ext) begin
                        s = count_src_pkg::SRC_EXT_PIN;
                    end
                end
                default: s = count_src_pkg::SRC_OFF;
            endcase
        end
        // the external pin is never a source in third pwm mode
        // software must avoid this pairing; the gate only keeps the counter safe
        if (c.third_pwm_mode && s == count_src_pkg::SRC_EXT_PIN) begin
            s = count_src_pkg::SRC_OFF;
        end
        return s;
    endfunction

    // one decode feeds both the tick mux and the reported source
    assign src_dec = decode(cfg);

    // ****************************************************************
    // tick routing
    // ****************************************************************
    // edge detector is low after reset, so a pin already high then
    // counts one edge on the first cycle out of reset
    assign pin_rise = ext_count_clock_pin & ~pin_r;

    // pick the enable of the decoded source; off gives no ticks
    // every source is an enable pulse of mclk, never a clock of its own
    always_comb begin
        pin_nxt    = ext_count_clock_pin;
        src_nxt    = src_dec;
        prohib_nxt = (src_dec == count_src_pkg::SRC_OFF);
        case (src_dec)
            count_src_pkg::SRC_HS_OSC:    tick_nxt = high_speed_osc_clock;
            count_src_pkg::SRC_MAIN:      tick_nxt = main_system_clock;
            count_src_pkg::SRC_SUB:       tick_nxt = subsystem_clock;
            count_src_pkg::SRC_CLK_DIV1:  tick_nxt = cpu_tick;
            count_src_pkg::SRC_CLK_DIV2:  tick_nxt = div2_tick;
            count_src_pkg::SRC_CLK_DIV4:  tick_nxt = div4_tick;
            count_src_pkg::SRC_CLK_DIV8:  tick_nxt = div8_tick;
            count_src_pkg::SRC_CLK_DIV32: tick_nxt = div32_tick;
            count_src_pkg::SRC_EXT_PIN:   tick_nxt = pin_rise;
            default:                      tick_nxt = 1'b0;
        endcase
    end

    // registered outputs: tick and source move on the same edge,
    // so a tick never shows under the label of the old source
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_r    <= 1'b0;
            tick_r   <= 1'b0;
            src_r    <= count_src_pkg::SRC_OFF;
            prohib_r <= 1'b0;
        end else begin
            pin_r    <= pin_nxt;
            tick_r   <= tick_nxt;
            src_r    <= src_nxt;
            prohib_r <= prohib_nxt;
        end
    end

    assign count_tick         = tick_r;
    assign count_src          = src_r;
    assign setting_prohibited = prohib_r;

endmodule
`default_nettype wire

// >>> hw/count_src_regs.svh
// constants for the timer count-source selector
`ifndef COUNT_SRC_REGS_SVH
`define COUNT_SRC_REGS_SVH

// ****************************************************************
// count-source code values
// ****************************************************************
`define CSRC_CODE_DIV1     3'h0
`define CSRC_CODE_DIV2     3'h1
`define CSRC_CODE_DIV4     3'h2
`define CSRC_CODE_DIV8     3'h3
`define CSRC_CODE_DIV32    3'h4
`define CSRC_CODE_EXT      3'h5

// ****************************************************************
// prescaler layout and reset values
// ****************************************************************
`define CSRC_PRESC_W       5
`define CSRC_PRESC_RST     5'h00
`define CSRC_DIV2_BITS     1
`define CSRC_DIV4_BITS     2
`define CSRC_DIV8_BITS     3
`define CSRC_DIV32_BITS    5

`endif

// >>> hw/count_src_pkg.sv
// types shared by the timer count-source selector
package count_src_pkg;

    // cpu/peripheral clock source, as reported by the clock generator
    typedef enum logic [2:0] {
        CPU_HS_OSC,
        CPU_LS_OSC,
        CPU_X1,
        CPU_PLL,
        CPU_XT1
    } cpu_src_e;

    // counting clock actually routed to the counter core
    typedef enum logic [3:0] {
        SRC_OFF,
        SRC_HS_OSC,
        SRC_MAIN,
        SRC_SUB,
        SRC_CLK_DIV1,
        SRC_CLK_DIV2,
        SRC_CLK_DIV4,
        SRC_CLK_DIV8,
        SRC_CLK_DIV32,
        SRC_EXT_PIN
    } count_src_e;

    // software configuration travelling together
    typedef struct packed {
        cpu_src_e    cpu_clock_src_sel;
        logic        osc_high_range_sel;
        logic        timer_clk_domain_sel;
        logic [2:0]  count_source_code;
        logic        third_pwm_mode;
    } cfg_s;

endpackage

// >>> hw/clk_prescaler.sv
// free-running prescaler of the cpu/peripheral clock enable
`timescale 1ns/1ps
`default_nettype none
`include "count_src_regs.svh"

module clk_prescaler (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // cpu/peripheral clock enable
    input  wire logic cpu_tick,
    // divided enables
    output logic      div2_tick,
    output logic      div4_tick,
    output logic      div8_tick,
    output logic      div32_tick
);

    logic [`CSRC_PRESC_W-1:0] cnt_r;
    logic [`CSRC_PRESC_W-1:0] cnt_nxt;

    // low bits all ones means this tick closes a divided period
    function automatic logic wrap(input logic [`CSRC_PRESC_W-1:0] c, input int unsigned n);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < n; i++) begin
            ok = ok & c[i];
        end
        return ok;
    endfunction

    // ****************************************************************
    // counter
    // ****************************************************************
    always_comb begin
        cnt_nxt = cnt_r;
        if (cpu_tick) begin
            cnt_nxt = cnt_r + `CSRC_PRESC_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_r <= `CSRC_PRESC_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // divided enables, one cpu tick wide
    assign div2_tick  = cpu_tick & wrap(cnt_r, `CSRC_DIV2_BITS);
    assign div4_tick  = cpu_tick & wrap(cnt_r, `CSRC_DIV4_BITS);
    assign div8_tick  = cpu_tick & wrap(cnt_r, `CSRC_DIV8_BITS);
    assign div32_tick = cpu_tick & wrap(cnt_r, `CSRC_DIV32_BITS);

endmodule
`default_nettype wire

// >>> sim/src_sel_asserts.sv
// assertion checker for the count-source selector
`timescale 1ns/1ps
`default_nettype none

module src_sel_asserts (
    // clock and reset
    input wire logic                      mclk,
    input wire logic                      reset,
    // inputs of the selector
    input wire count_src_pkg::cfg_s       cfg,
    input wire logic                      cpu_tick,
    input wire logic                      high_speed_osc_clock,
    input wire logic                      main_system_clock,
    input wire logic                      subsystem_clock,
    input wire logic                      ext_count_clock_pin,
    // outputs of the selector
    input wire logic                      count_tick,
    input wire count_src_pkg::count_src_e count_src,
    input wire logic                      setting_prohibited
);
    // short views of the setting
    wire [2:0] code = cfg.count_source_code;
    wire       lo0  = !cfg.osc_high_range_sel && !cfg.timer_clk_domain_sel;
    wire       hi0  = cfg.osc_high_range_sel && !cfg.timer_clk_domain_sel;

    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    div1_select_a: assert property (lo0 && code == 3'h0
        |=> count_src == count_src_pkg::SRC_CLK_DIV1)
        else $error("undivided cpu clock not selected");
    hs_select_a: assert property (hi0 && code == 3'h0
        && cfg.cpu_clock_src_sel == count_src_pkg::CPU_HS_OSC
        |=> count_src == count_src_pkg::SRC_HS_OSC) else $error("hs osc not selected");
    hs_prohib_a: assert property (hi0 && code inside {[3'h1:3'h4]}
        |=> setting_prohibited) else $error("divided code accepted in high range");
    gate_off_a: assert property (setting_prohibited
        |-> !count_tick && count_src == count_src_pkg::SRC_OFF)
        else $error("clock passed while prohibited");
    ext_edge_a: assert property (!cfg.timer_clk_domain_sel && code == 3'h5
        && !cfg.third_pwm_mode && !$past(reset) && $rose(ext_count_clock_pin)
        |=> count_tick) else $error("pin edge lost");
    ext_pwm_a: assert property (code == 3'h5 && cfg.third_pwm_mode
        |=> setting_prohibited) else $error("pin accepted in third pwm mode");
    div1_follow_a: assert property (count_src == count_src_pkg::SRC_CLK_DIV1
        |-> count_tick == $past(cpu_tick)) else $error("tick not following cpu clock");
    div2_space_a: assert property ((count_tick
        && count_src == count_src_pkg::SRC_CLK_DIV2)
        ##1 count_src == count_src_pkg::SRC_CLK_DIV2 |-> !count_tick)
        else $error("div2 too fast");
endmodule

bind count_src_sel src_sel_asserts chk (.mclk(mclk), .reset(reset), .cfg(cfg),
    .cpu_tick(cpu_tick), .high_speed_osc_clock(high_speed_osc_clock),
    .main_system_clock(main_system_clock), .subsystem_clock(subsystem_clock),
    .ext_count_clock_pin(ext_count_clock_pin), .count_tick(count_tick),
    .count_src(count_src), .setting_prohibited(setting_prohibited));
`default_nettype wire

// >>> sim/clk_gen_model.sv
// clock generator and pin model feeding the selector
`timescale 1ns/1ps
`default_nettype none

module clk_gen_model (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // clock enables and external pin
    output logic      cpu_tick,
    output logic      hs_tick,
    output logic      main_tick,
    output logic      sub_tick,
    output logic      ext_pin
);
    logic [2:0] phase_r;
    logic [2:0] phase_nxt;

    // sources run from reset on, before any selection is written
    always_comb begin
        phase_nxt = reset ? 3'h0 : phase_r + 3'h1;
    end

    // phase register
    always_ff @(posedge mclk) begin
        phase_r <= phase_nxt;
    end

    // periods: cpu 2, hs osc 2 in the other phase, sub 4, main 8, pin 8
    assign cpu_tick  = ~phase_r[0];
    assign hs_tick   = phase_r[0];
    assign sub_tick  = (phase_r[1:0] == 2'h3);
    assign main_tick = (phase_r == 3'h7);
    assign ext_pin   = phase_r[2];
endmodule
`default_nettype wire

// >>> sim/test_count_src_sel.sv
// self-checking testbench of the count-source selector
`timescale 1ns/1ps
`default_nettype none

module test_count_src_sel;
    logic                      mclk = 1'b0;
    logic                      reset = 1'b1;
    count_src_pkg::cfg_s       cfg = '0;
    logic                      cpu_tick;
    logic                      hs_tick;
    logic                      main_tick;
    logic                      sub_tick;
    logic                      ext_pin;
    logic                      count_tick;
    count_src_pkg::count_src_e count_src;
    logic                      prohib;
    int                        err_count = 0;
    int                        samples_checked = 0;

    // 100 MHz clock
    always #5 mclk = ~mclk;

    // far side and selector
    clk_gen_model gen (.mclk(mclk), .reset(reset), .cpu_tick(cpu_tick), .hs_tick(hs_tick),
        .main_tick(main_tick), .sub_tick(sub_tick), .ext_pin(ext_pin));
    count_src_sel uut (.mclk(mclk), .reset(reset), .cfg(cfg), .cpu_tick(cpu_tick),
        .high_speed_osc_clock(hs_tick), .main_system_clock(main_tick),
        .subsystem_clock(sub_tick), .ext_count_clock_pin(ext_pin), .count_tick(count_tick),
        .count_src(count_src), .setting_prohibited(prohib));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // apply a setting, then judge source, flag and ticks in 64 cycles
    task automatic run_case(input count_src_pkg::cpu_src_e cpu, input logic hi, input logic dom,
        input logic [2:0] code, input logic pwm, input count_src_pkg::count_src_e src,
        input logic [7:0] n_exp);
        logic [7:0] n;
        @(negedge mclk);
        cfg = '{cpu, hi, dom, code, pwm};
        repeat (2) @(negedge mclk);
        check(8'(count_src), 8'(src));
        check({7'h00, prohib}, {7'h00, src == count_src_pkg::SRC_OFF});
        n = 8'h00;
        repeat (64) begin
            @(negedge mclk);
            n = n + {7'h00, count_tick};
        end
        check(n, n_exp);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_divs();
        for (int i = 0; i < 5; i++) begin
            run_case(count_src_pkg::CPU_HS_OSC, 1'b0, 1'b0, 3'(i), 1'b0,
                count_src_pkg::count_src_e'(count_src_pkg::SRC_CLK_DIV1 + i),
                8'h20 >> (i == 4 ? 5 : i));
        end
        $display("test divs done");
    endtask

    task automatic test_high();
        run_case(count_src_pkg::CPU_HS_OSC, 1'b1, 1'b0, 3'h0, 1'b0,
            count_src_pkg::SRC_HS_OSC, 8'h20);
        for (int i = 1; i < 5; i++) begin
            run_case(count_src_pkg::CPU_HS_OSC, 1'b1, 1'b0, 3'(i), 1'b0,
                count_src_pkg::SRC_OFF, 8'h00);
        end
        $display("test high range done");
    endtask

    task automatic test_ext();
        run_case(count_src_pkg::CPU_HS_OSC, 1'b0, 1'b0, 3'h5, 1'b0,
            count_src_pkg::SRC_EXT_PIN, 8'h08);
        run_case(count_src_pkg::CPU_PLL, 1'b1, 1'b1, 3'h5, 1'b0,
            count_src_pkg::SRC_EXT_PIN, 8'h08);
        run_case(count_src_pkg::CPU_HS_OSC, 1'b0, 1'b0, 3'h5, 1'b1,
            count_src_pkg::SRC_OFF, 8'h00);
        for (int i = 6; i < 8; i++) begin
            run_case(count_src_pkg::CPU_HS_OSC, 1'b0, 1'b0, 3'(i), 1'b0,
                count_src_pkg::SRC_OFF, 8'h00);
        end
        $display("test external pin done");
    endtask

    task automatic test_sources();
        run_case(count_src_pkg::CPU_XT1, 1'b0, 1'b1, 3'h0, 1'b0,
            count_src_pkg::SRC_SUB, 8'h10);
        run_case(count_src_pkg::CPU_LS_OSC, 1'b0, 1'b1, 3'h0, 1'b0,
            count_src_pkg::SRC_SUB, 8'h10);
        run_case(count_src_pkg::CPU_HS_OSC, 1'b0, 1'b1, 3'h0, 1'b0,
            count_src_pkg::SRC_OFF, 8'h00);
        run_case(count_src_pkg::CPU_PLL, 1'b1, 1'b0, 3'h0, 1'b0,
            count_src_pkg::SRC_MAIN, 8'h08);
        run_case(count_src_pkg::CPU_LS_OSC, 1'b1, 1'b0, 3'h0, 1'b0,
            count_src_pkg::SRC_OFF, 8'h00);
        run_case(count_src_pkg::CPU_LS_OSC, 1'b1, 1'b1, 3'h0, 1'b0,
            count_src_pkg::SRC_HS_OSC, 8'h20);
        run_case(count_src_pkg::CPU_X1, 1'b1, 1'b1, 3'h0, 1'b0,
            count_src_pkg::SRC_OFF, 8'h00);
        $display("test cpu sources done");
    endtask

    // verdict and end of run
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(negedge mclk);
        reset = 1'b0;
        test_divs();
        test_high();
        test_ext();
        test_sources();
        finish_test();
    end

    // watchdog
    initial begin
        #50000;
        err_count++;
        finish_test();
    end
endmodule
`default_nettype wire
